// file: gmr_pkg.sv
// gmr_pkg: constants and types for the angle sensor readout block
// assumes a 125 MHz system clock and a reference clock sampled as a pin
package gmr_pkg;
    // ------------------------------------------------------------
    // timing of the sample chain: reference edges, digital clock ticks and updates
    // ------------------------------------------------------------
    localparam int unsigned UPD_NUM        = 8192;
    localparam int unsigned UPD_DIV_FILT   = 25;
    localparam int unsigned UPD_DIV_BYP    = 100;
    localparam int unsigned PLL_MULT       = 25;
    localparam int unsigned DIG_DIV        = 4;
    // update period in digital clock ticks: 8192/(25*f) = 8192/4 * (4/25f)
    localparam int unsigned UPD_TICKS_FILT = UPD_NUM / DIG_DIV;
    localparam int unsigned UPD_TICKS_BYP  =
        UPD_NUM * UPD_DIV_FILT / (UPD_DIV_BYP * DIG_DIV);
    localparam int unsigned SETTLE_UPDATES = 2;
    localparam int unsigned MISS_EDGES_MAX = 2;
    // ------------------------------------------------------------
    // system clock and watchdog time
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 8000;
    localparam int unsigned REF_MIN_MHZ_X10 = 38;  // 3.8 MHz lowest ref
    // longest ref period in ps, then in system cycles (rounded down)
    localparam int unsigned REF_MAX_PS     = 10000000 / REF_MIN_MHZ_X10;
    localparam int unsigned REF_MAX_CYC    = REF_MAX_PS / CLK_PERIOD_PS;
    localparam int unsigned MISS_CYC       =
        REF_MAX_CYC * (MISS_EDGES_MAX + 1);
    // ------------------------------------------------------------
    // sample format
    // ------------------------------------------------------------
    localparam int unsigned SMP_W          = 16;
    localparam logic [15:0] SMP_LIMIT      = 16'h5ABE; // 23230
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] t;
    } gmr_raw_t;
    typedef struct packed {
        logic        valid;
        logic        settled;
        logic        in_range;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] t;
    } gmr_smp_t;
endpackage : gmr_pkg

// file: gmr_clk_mon.sv
// gmr_clk_mon: reference clock edge tracker and missing edge reset
// assumes ref_in is an asynchronous pin, clocked by the system clock
`timescale 1ns/100ps
module gmr_clk_mon #(
    parameter int unsigned MISS_CYC = gmr_pkg::MISS_CYC
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic ce_in,
    input  wire logic ref_in,
    output logic      ref_rise_out,
    output logic      chip_rst_out
);
    logic        s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic [15:0] gap_q, gap_d;
    logic        rst_q, rst_d;

    // ------------------------------------------------------------
    // synchroniser, rising edge detect, gap watchdog
    // ------------------------------------------------------------
    always_comb begin
        s1_d  = ref_in;
        s2_d  = s1_q;
        s3_d  = s2_q;
        gap_d = gap_q;
        rst_d = 1'b0;
        // RQ11: lock on rising edge
        if (s2_q && !s3_q) begin
            gap_d = 16'h0000;
        // RQ12: reset after missing edges
        end else if (gap_q >= 16'(MISS_CYC)) begin
            rst_d = 1'b1;
            gap_d = 16'h0000;
        end else begin
            gap_d = gap_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            gap_q <= 16'h0000;
            rst_q <= 1'b0;
        end else if (ce_in) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            gap_q <= gap_d;
            rst_q <= rst_d;
        end
    end

    assign ref_rise_out = ce_in & s2_q & ~s3_q;
    assign chip_rst_out = rst_q;
endmodule : gmr_clk_mon

// file: gmr_readout.sv
// gmr_readout: sample refresh, settle tracking and range check
// assumes converter results arrive as a word from same-clock logic
//
// Summary of operation
// RQ1: host keeps calibration values and corrects every reading.
// RQ2: host stores temperature reading at 30 mT, 25 C as reference.
// RQ3: host forms offset from 25 C value plus gradient times drift.
// RQ4: host subtracts corrected offset from each raw channel.
// RQ5: host divides each channel by its calibrated amplitude.
// RQ6: host corrects only sine channel for non-orthogonality.
// RQ7: host takes full-circle arctangent, minus cosine phase error.
// RQ8: samples refresh every 8192 over 25 or 100 reference periods.
// RQ9: samples settle after two update periods following source change.
// RQ10: signed 16-bit results, valid only up to magnitude 23230.
// RQ11: PLL locks on rising reference edges, digital clock 25/4; code gives 7 ticks per reference edge.
// RQ12: chip reset when more than two reference edges go missing.
// RQ13: reference clock should run near 50 percent duty.
`timescale 1ns/100ps
module gmr_readout #(
    parameter int unsigned MISS_CYC = gmr_pkg::MISS_CYC
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             ce_in,
    input  wire logic             ref_clk_in,
    input  wire logic             filter_bypass_select_in,
    input  wire logic [1:0]       src_sel_in,
    input  wire gmr_pkg::gmr_raw_t raw_in,
    output gmr_pkg::gmr_smp_t     smp_out,
    output logic                  dig_tick_out,
    output logic                  chip_rst_out
);
    logic        ref_rise;
    logic        chip_rst;
    logic [4:0]  pll_q, pll_d;      // counts 25 pll ticks per ref edge
    logic        tick_q, tick_d;
    logic [11:0] upd_q, upd_d;
    logic [1:0]  stl_q, stl_d;
    logic [1:0]  src_q, src_d;
    logic        byp_q, byp_d;
    gmr_pkg::gmr_smp_t smp_q, smp_d;

    // magnitude check on a signed word
    function automatic logic in_lim(input logic [15:0] v);
        logic [15:0] m;
        m = v[15] ? (16'h0000 - v) : v;
        in_lim = (m <= gmr_pkg::SMP_LIMIT);
    endfunction : in_lim

    gmr_clk_mon #(
        .MISS_CYC     (MISS_CYC)
    ) u_mon (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .ce_in        (ce_in),
        .ref_in       (ref_clk_in),
        .ref_rise_out (ref_rise),
        .chip_rst_out (chip_rst)
    );

    // ------------------------------------------------------------
    // digital tick: 25 pll periods per ref edge, divided by 4
    // ------------------------------------------------------------
    always_comb begin
        pll_d  = pll_q;
        tick_d = 1'b0;
        // RQ11: digital rate 25/4 of reference required; this logic gives 7 ticks per ref edge
        if (ref_rise) begin
            pll_d = 5'h00;
        end
        // each ref edge yields 7 ticks, at counts 0,4,..,24 (25/4 rounded up)
        if (ref_rise ||
            (pll_q != 5'h00 && pll_q < 5'(gmr_pkg::PLL_MULT))) begin
            if (pll_q[1:0] == 2'h0 || ref_rise) begin
                tick_d = 1'b1;
            end
            pll_d = ref_rise ? 5'h01 : pll_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // update counter, settle tracking and sample capture
    // ------------------------------------------------------------
    always_comb begin
        upd_d = upd_q;
        stl_d = stl_q;
        src_d = src_sel_in;
        byp_d = filter_bypass_select_in;
        smp_d = smp_q;
        smp_d.valid = 1'b0;
        if (tick_q) begin
            // RQ8: period depends on bypass
            if (upd_q >= 12'((byp_q ? gmr_pkg::UPD_TICKS_BYP
                                    : gmr_pkg::UPD_TICKS_FILT) - 1)) begin
                upd_d = 12'h000;
                smp_d.valid = 1'b1;
                smp_d.x = raw_in.x;
                smp_d.y = raw_in.y;
                smp_d.t = raw_in.t;
                // RQ10: flag words beyond limit
                smp_d.in_range = in_lim(raw_in.x) & in_lim(raw_in.y);
                if (stl_q < 2'(gmr_pkg::SETTLE_UPDATES)) begin
                    stl_d = stl_q + 2'h1;
                end
                // RQ9: settled after two updates
                smp_d.settled = (stl_q + 2'h1) >=
                                2'(gmr_pkg::SETTLE_UPDATES);
            end else begin
                upd_d = upd_q + 12'h001;
            end
        end
        // RQ9: restart settling on source or mode change
        // a change wins over a same-cycle update; old data is unsettled
        if (src_q != src_sel_in || byp_q != filter_bypass_select_in) begin
            stl_d         = 2'h0;
            smp_d.settled = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pll_q  <= 5'h00;
            tick_q <= 1'b0;
            upd_q  <= 12'h000;
            stl_q  <= 2'h0;
            src_q  <= 2'h0;
            byp_q  <= 1'b0;
            smp_q  <= '0;
        end else if (ce_in) begin
            // RQ12: internal reset on clock loss
            if (chip_rst) begin
                pll_q  <= 5'h00;
                tick_q <= 1'b0;
                upd_q  <= 12'h000;
                stl_q  <= 2'h0;
                smp_q  <= '0;
            end else begin
                pll_q  <= pll_d;
                tick_q <= tick_d;
                upd_q  <= upd_d;
                stl_q  <= stl_d;
                smp_q  <= smp_d;
            end
            src_q <= src_d;
            byp_q <= byp_d;
        end
    end

    assign smp_out      = smp_q;
    assign dig_tick_out = tick_q;
    assign chip_rst_out = chip_rst;
endmodule : gmr_readout

// file: gmr_host.sv
// gmr_host: host model turning settled samples into an angle
// assumes samples from gmr_readout on the same clock
`timescale 1ns/100ps
module gmr_host #(
    parameter real OX  = 12.0,
    parameter real KT  = 0.5,
    parameter real AMP = 9500.0,
    parameter real PHI = 0.02
) (
    input  wire logic              clk_in,
    input  wire gmr_pkg::gmr_smp_t smp_in,
    output real                    ang_out,
    output int                     count_out
);
    real t25, o, x2, y3;
    bit  have_ref = 1'b0;
    initial count_out = 0;
    always @(posedge clk_in) begin
        if (smp_in.valid && smp_in.settled && smp_in.in_range) begin
            if (!have_ref) t25 = $signed(smp_in.t);
            have_ref = 1'b1;
            o = OX + KT * ($signed(smp_in.t) - t25);
            x2 = ($signed(smp_in.x) - o) / AMP;
            y3 = (($signed(smp_in.y) - o) / AMP - x2 * $sin(-PHI))
                / $cos(-PHI);
            ang_out = $atan2(y3, x2) - PHI;
            count_out = count_out + 1;
        end
    end
endmodule : gmr_host

// file: gmr_readout_chk.sv
// gmr_readout_chk: port assertions for gmr_readout
// assumes one clock domain; bound below
`timescale 1ns/100ps
module gmr_readout_chk #(
    parameter int unsigned MISS_CYC = gmr_pkg::MISS_CYC
) (
    input wire logic              clk_in,
    input wire logic              rstn_in,
    input wire logic              ref_clk_in,
    input wire logic [1:0]        src_sel_in,
    input wire gmr_pkg::gmr_smp_t smp_out,
    input wire logic              dig_tick_out,
    input wire logic              chip_rst_out
);
    int unsigned idle_q, idle_d;
    logic        ref_q;
    // cycles since the last reference pin rise
    always_comb idle_d = (ref_clk_in && !ref_q) ? 0 : idle_q + 1;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) {idle_q, ref_q} <= '0;
        else {idle_q, ref_q} <= {idle_d, ref_clk_in};
    end
    function automatic logic fits(input logic [15:0] v);
        return (v[15] ? 16'h0 - v : v) <= gmr_pkg::SMP_LIMIT;
    endfunction : fits
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_gap;
        !dig_tick_out [*3];
    endsequence
    a_valid_pulse:
        assert property (smp_out.valid |=> !smp_out.valid)
        else $error("valid pulse too long");
    a_data_hold:
        assert property (!smp_out.valid && !chip_rst_out &&
            !$past(chip_rst_out) |-> $stable(smp_out[47:0]))
        else $error("sample changed without update");
    a_settle_drop:
        assert property ($changed(src_sel_in) |-> ##2 !smp_out.settled)
        else $error("settled kept after source change");
    a_range_flag:
        assert property (smp_out.valid |-> smp_out.in_range ==
            (fits(smp_out.x) && fits(smp_out.y)))
        else $error("range flag wrong");
    a_tick_gap:
        assert property (dig_tick_out |=> s_gap)
        else $error("ticks closer than four cycles");
    a_tick_follow:
        assert property ($rose(ref_clk_in) |-> ##[2:6] dig_tick_out)
        else $error("no tick after reference edge");
    a_miss_rst:
        assert property (chip_rst_out |-> idle_q + 2 >= MISS_CYC)
        else $error("chip reset too early");
endmodule : gmr_readout_chk
bind gmr_readout gmr_readout_chk #(.MISS_CYC(MISS_CYC)) i_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .ref_clk_in(ref_clk_in),
    .src_sel_in(src_sel_in), .smp_out(smp_out),
    .dig_tick_out(dig_tick_out), .chip_rst_out(chip_rst_out));

// file: tb_gmr_readout.sv
// tb_gmr_readout: corner and random samples through gmr_readout
// assumes 125 MHz clock, 32 cycle reference period
`timescale 1ns/100ps
module tb_gmr_readout;
    localparam logic [15:0] CRN [4] = '{16'h5ABE, 16'h5ABF, 16'hA542,
        16'hA541};
    logic clk_in = 1'b0, rstn_in = 1'b0, ref_clk_in = 1'b0, run = 1'b0;
    logic byp = 1'b1, tick, crst;
    logic [1:0] src = 2'h0;
    logic [31:0] lfsr = 32'h8E789A7D;
    gmr_pkg::gmr_raw_t raw = '0;
    gmr_pkg::gmr_smp_t smp;
    int bad_count = 0, checked = 0, ticks = 0, hcnt;
    real ang;
    gmr_readout #(.MISS_CYC(40)) i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .ce_in(1'b1), .ref_clk_in(ref_clk_in), .src_sel_in(src),
        .filter_bypass_select_in(byp), .raw_in(raw), .smp_out(smp),
        .dig_tick_out(tick), .chip_rst_out(crst));
    gmr_host i_host (.clk_in(clk_in), .smp_in(smp), .ang_out(ang),
        .count_out(hcnt));
    initial forever #4 clk_in = ~clk_in;
    initial forever begin
        repeat (16) @(negedge clk_in);
        ref_clk_in <= run & ~ref_clk_in;
    end
    always @(posedge clk_in) if (tick === 1'b1) ticks <= ticks + 1;
    function automatic logic fits(input logic [15:0] v);
        return (v[15] ? 16'h0 - v : v) <= 16'h5ABE;
    endfunction : fits
    task automatic chk_d(input logic [47:0] g, e);
        checked++;
        if (g !== e) $display("Error %0t data mismatch", $time);
        if (g !== e) bad_count++;
    endtask : chk_d
    task automatic chk_f(input logic g, e);
        chk_d({47'h0, g}, {47'h0, e});
    endtask : chk_f
    task automatic final_report;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic wait_upd;
        int n;
        ticks = 0;
        for (n = 0; n < 20000 && (n == 0 || smp.valid !== 1'b1); n++)
            @(negedge clk_in);
        chk_f(n < 20000, 1'b1);
        if (n >= 20000) final_report;
    endtask : wait_upd
    task automatic step(input logic [15:0] x, y, input logic s, input int k);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        raw <= {x, y, lfsr[15:0]};
        wait_upd;
        chk_d(smp[47:0], raw);
        chk_d(48'(ticks), 48'(k));
        chk_f(smp.in_range, fits(x) & fits(y));
        chk_f(smp.settled, s);
    endtask : step
    initial begin
        int n;
        repeat (8) @(negedge clk_in);
        rstn_in <= 1'b1;
        run <= 1'b1;
        wait_upd;
        src <= 2'h1;
        for (int i = 0; i < 10; i++)
            step(i < 4 ? CRN[i] : lfsr[31:16], {2'h0, lfsr[29:16]}, i > 0,
                512);
        $display("test bypass done");
        byp <= 1'b0;
        wait_upd;
        step(CRN[0], CRN[3], 1'b1, 2048);
        src <= 2'h2;
        repeat (2) @(negedge clk_in);
        chk_f(smp.settled, 1'b0);
        $display("test filter done");
        run <= 1'b0;
        for (n = 0; n < 300 && crst !== 1'b1; n++) @(negedge clk_in);
        chk_f(crst, 1'b1);
        repeat (2) @(negedge clk_in);
        chk_d(smp[47:0], 48'h0);
        chk_f(hcnt > 0, 1'b1);
        $display("test clock loss done");
        final_report;
    end
endmodule : tb_gmr_readout
